/* logic/mss_pkg.sv */
// Package for the motor start sequencer: register map, field layout, timing counts, states
package mss_pkg;
    // Register byte offsets (avs_address is decoded against these directly)
    localparam logic [7:0] MSS_REG_CTRL = 8'h00;
    localparam logic [7:0] MSS_REG_START = 8'h04;
    localparam logic [7:0] MSS_REG_STATUS = 8'h08;
    localparam logic [7:0] MSS_REG_SPEED = 8'h0c;
    // Control register fields
    localparam int MSS_F_SD_EN = 0;
    localparam int MSS_F_RD_EN = 1;
    localparam int MSS_F_REL_MD = 2;
    localparam int MSS_F_STAT_LO = 4;
    localparam int MSS_F_RVS_LO = 6;
    localparam int MSS_F_BRK_T_LO = 8;
    localparam int MSS_F_BRK_I_LO = 11;
    localparam int MSS_F_PRB_I_LO = 14;
    localparam int MSS_F_ADV_LO = 18;
    localparam int MSS_F_OLC_LO = 20;
    // Start register fields
    localparam int MSS_F_SETTLE_LO = 0;
    localparam int MSS_F_ACC1_LO = 3;
    localparam int MSS_F_ACC2_LO = 6;
    localparam int MSS_F_HAND_LO = 9;
    localparam logic [31:0] MSS_CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] MSS_START_RST = 32'h0000_0000;
    // Timing: base time units, converted to ref_clk cycles at 100 MHz
    localparam int MSS_CLK_MHZ = 100;
    localparam int MSS_UNIT_US = 10;
    localparam int MSS_UNIT_CYC = MSS_UNIT_US * MSS_CLK_MHZ;
    localparam int MSS_PROBE_MAX_US = 20;
    localparam int MSS_PROBE_MAX_CYC = MSS_PROBE_MAX_US * MSS_CLK_MHZ;
    localparam int MSS_CNT_W = 24;
    localparam logic [2:0] MSS_NUM_PAIRS = 3'h6;
    // Phase pair codes: {drive high phase, drive low phase}, order VW WV UV VU WU UW
    localparam logic [1:0] MSS_PH_U = 2'h0;
    localparam logic [1:0] MSS_PH_V = 2'h1;
    localparam logic [1:0] MSS_PH_W = 2'h2;
    typedef enum logic [12:0] {
        MSS_S_POWER_ON  = 13'h0001,
        MSS_S_SD_CHECK  = 13'h0002,
        MSS_S_SPEED_DET = 13'h0004,
        MSS_S_STAT_CHK  = 13'h0008,
        MSS_S_FWD_CHK   = 13'h0010,
        MSS_S_RVS_CHK   = 13'h0020,
        MSS_S_RD_CHECK  = 13'h0040,
        MSS_S_RVS_DRIVE = 13'h0080,
        MSS_S_BRK_CHECK = 13'h0100,
        MSS_S_BRAKE     = 13'h0200,
        MSS_S_PRB_CHECK = 13'h0400,
        MSS_S_PROBE     = 13'h0800,
        MSS_S_SETTLE    = 13'h1000
    } mss_state_t;
    typedef enum logic [1:0] {
        MSS_S2_NONE   = 2'h0,
        MSS_S2_ACCEL  = 2'h1,
        MSS_S2_CLOSED = 2'h2
    } mss_run_t;
endpackage : mss_pkg

/* logic/mss_edge_if.sv */
// Interface carrying synchronised comparator edges to the sequencer
`timescale 1ns/10ps
interface mss_edge_if;
    logic uv_lvl;
    logic uw_lvl;
    logic uv_rise;
    logic uw_rise;
    logic any_toggle;
    modport src (output uv_lvl, output uw_lvl, output uv_rise, output uw_rise, output any_toggle);
    modport dst (input uv_lvl, input uw_lvl, input uv_rise, input uw_rise, input any_toggle);
endinterface : mss_edge_if

/* logic/mss_cmp_sync.sv */
// Comparator synchroniser and edge detector
`timescale 1ns/10ps
module mss_cmp_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw comparator pins
    input wire logic cmp_uv,
    input wire logic cmp_uw,
    // Edges out
    mss_edge_if.src edge_o
);
    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic [1:0] prev_r;
    // Chain runs through reset so the detector starts at the pin level, not a false edge
    always_ff @(posedge ref_clk) begin
        meta_r <= {cmp_uw, cmp_uv};
        sync_r <= meta_r;
        prev_r <= sync_r;
    end
    assign edge_o.uv_lvl = sync_r[0];
    assign edge_o.uw_lvl = sync_r[1];
    assign edge_o.uv_rise = sync_r[0] & ~prev_r[0] & ~rst;
    assign edge_o.uw_rise = sync_r[1] & ~prev_r[1] & ~rst;
    assign edge_o.any_toggle = |(sync_r ^ prev_r) & ~rst;
endmodule : mss_cmp_sync

/* logic/mss_sequencer.sv */
// Motor start sequencer top: Avalon-MM registers, start state machine, phase drive
// How it works
// - Reset or standby exit enters power-on state, then checks speed-detect enable.
// - Enable set goes to speed detect; clear treats motor stationary, to brake check.
// - Speed under stationary threshold goes to brake check; otherwise direction check.
// - Forward rotation hands off to closed loop seeded from measured position; drive_rate keeps the rate loaded at an earlier fast reverse, else zero.
// - Fast reverse returns to speed detect; slow reverse goes to reverse-drive check.
// - Reverse-drive enable set enters reverse drive; else brake check.
// - Reverse drive pushes forward until zero speed, then accelerates.
// - Nonzero brake-done time enables braking; zero skips to probe check.
// - Brake turns on all low-side switches, all high-side off.
// - Brake exits after current stays low for brake-done time, then probe check.
// - Nonzero probe current limit enables probing; otherwise align.
// - Align drives current into V out of W for settle duration, then accelerate.
// - Probe completion moves to accelerate.
// - Accelerate ramps rate by two coefficients; closed loop above handoff threshold.
// - Direction pin change stops drive and restarts from power-on.
// - Speed detect floats all phases and watches comparator crossings.
// - UW lagging UV means forward; UW leading UV means reverse.
// - Speed comes from time since the last toggle of either comparator, taken at a rising edge.
// - No comparator toggle within stationary window means stationary.
// - Probe pairs VW WV UV VU WU UW, stop at current limit, record time.
// - Shortest probe time pair is taken as rotor position.
// - Release mode 0 keeps low side on; mode 1 floats both switches.
// - After probing, drive starts advanced by the advance-angle field.
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
module mss_sequencer
    import mss_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Device pins and analog status
    input wire logic standby,
    input wire logic dir_pin,
    input wire logic cmp_uv,
    input wire logic cmp_uw,
    input wire logic cur_below_brake,
    input wire logic cur_at_probe,
    input wire logic [2:0] phase_seed,
    // Phase switch gates and start handoff outputs
    output logic [2:0] high_on,
    output logic [2:0] low_on,
    output logic closed_loop,
    output logic accel_active,
    output logic [1:0] open_loop_current_level,
    output logic [2:0] drive_phase_init,
    output logic [15:0] drive_rate
);
    import mss_pkg::*;

    mss_edge_if edges ();
    mss_cmp_sync u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .cmp_uv(cmp_uv),
        .cmp_uw(cmp_uw),
        .edge_o(edges)
    );

    // Level inputs from pins pass two flops
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic dir_prev_r;
    logic stby_prev_r;
    logic [31:0] ctrl_r;
    logic [31:0] start_r;
    mss_state_t state_r, state_nxt;
    mss_run_t run_r, run_nxt;
    logic [MSS_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [MSS_CNT_W-1:0] period_r;
    logic [MSS_CNT_W-1:0] best_r;
    logic [2:0] pair_r;
    logic [2:0] best_pair_r;
    logic probe_gap_r;
    logic fwd_r;
    logic [2:0] last_edge_r;
    logic [1:0] rise_cnt_r;
    logic [15:0] rate_r;
    logic [15:0] accel_r;
    logic ack_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {cur_below_brake, standby, dir_pin};
            pin_sync_r <= pin_meta_r;
        end
    end
    wire dir_s = pin_sync_r[0];
    wire stby_s = pin_sync_r[1];
    wire brk_low_s = pin_sync_r[2];

    // Field views
    wire sd_en = ctrl_r[MSS_F_SD_EN];
    wire rd_en = ctrl_r[MSS_F_RD_EN];
    wire rel_md = ctrl_r[MSS_F_REL_MD];
    wire [1:0] stat_thr = ctrl_r[MSS_F_STAT_LO +: 2];
    wire [1:0] rvs_lim = ctrl_r[MSS_F_RVS_LO +: 2];
    wire [2:0] brk_time = ctrl_r[MSS_F_BRK_T_LO +: 3];
    wire [3:0] prb_lim = ctrl_r[MSS_F_PRB_I_LO +: 4];
    wire [1:0] adv = ctrl_r[MSS_F_ADV_LO +: 2];
    wire [2:0] settle = start_r[MSS_F_SETTLE_LO +: 3];
    wire [2:0] acc1 = start_r[MSS_F_ACC1_LO +: 3];
    wire [2:0] acc2 = start_r[MSS_F_ACC2_LO +: 3];
    wire [4:0] hand_thr = start_r[MSS_F_HAND_LO +: 5];

    // Code to cycle count: units times 2^code
    function automatic logic [MSS_CNT_W-1:0] mss_span(input logic [3:0] code);
        mss_span = MSS_CNT_W'(MSS_UNIT_CYC) << code;
    endfunction : mss_span

    // Phase pair for probe index: {high phase, low phase}
    function automatic logic [3:0] mss_pair(input logic [2:0] idx);
        case (idx)
            3'h0: mss_pair = {MSS_PH_V, MSS_PH_W};
            3'h1: mss_pair = {MSS_PH_W, MSS_PH_V};
            3'h2: mss_pair = {MSS_PH_U, MSS_PH_V};
            3'h3: mss_pair = {MSS_PH_V, MSS_PH_U};
            3'h4: mss_pair = {MSS_PH_W, MSS_PH_U};
            default: mss_pair = {MSS_PH_U, MSS_PH_W};
        endcase
    endfunction : mss_pair

    function automatic logic [2:0] mss_onehot(input logic [1:0] ph);
        mss_onehot = 3'h1 << ph;
    endfunction : mss_onehot

    wire restart = (dir_s != dir_prev_r) | (stby_prev_r & ~stby_s) | stby_s;
    wire [MSS_CNT_W-1:0] stat_win = mss_span({2'h0, stat_thr} + 4'h4);
    wire [MSS_CNT_W-1:0] rvs_win = mss_span({2'h0, rvs_lim} + 4'h2);
    wire [MSS_CNT_W-1:0] brk_win = mss_span({1'b0, brk_time} + 4'h3);
    wire [MSS_CNT_W-1:0] settle_win = mss_span({1'b0, settle} + 4'h4);
    wire any_rise = edges.uv_rise | edges.uw_rise;
    wire [3:0] cur_pair = mss_pair(pair_r);
    wire [15:0] hand_rate = {hand_thr, 11'h000};
    wire probe_hit = cur_at_probe | (cnt_r >= MSS_CNT_W'(MSS_PROBE_MAX_CYC));

    // Next state, one transition per cycle
    always_comb begin
        state_nxt = state_r;
        run_nxt = run_r;
        cnt_nxt = cnt_r + 1'b1;
        if (restart) begin
            state_nxt = MSS_S_POWER_ON;
            run_nxt = MSS_S2_NONE;
            cnt_nxt = '0;
        end else if (run_r == MSS_S2_ACCEL) begin
            if (rate_r > hand_rate) begin
                run_nxt = MSS_S2_CLOSED;
            end
        end else if (run_r == MSS_S2_NONE) begin
            case (state_r)
                MSS_S_POWER_ON: begin
                    state_nxt = MSS_S_SD_CHECK;
                end
                MSS_S_SD_CHECK: begin
                    state_nxt = sd_en ? MSS_S_SPEED_DET : MSS_S_BRK_CHECK;
                    cnt_nxt = '0;
                end
                MSS_S_SPEED_DET: begin
                    if (any_rise && rise_cnt_r != 2'h0) begin
                        state_nxt = MSS_S_STAT_CHK;
                    end else if (edges.any_toggle) begin
                        cnt_nxt = '0;
                    end else if (cnt_r >= stat_win) begin
                        state_nxt = MSS_S_BRK_CHECK;
                    end
                end
                MSS_S_STAT_CHK: begin
                    state_nxt = (period_r >= stat_win) ? MSS_S_BRK_CHECK : MSS_S_FWD_CHK;
                end
                MSS_S_FWD_CHK: begin
                    if (fwd_r) begin
                        run_nxt = MSS_S2_CLOSED;
                    end else begin
                        state_nxt = MSS_S_RVS_CHK;
                    end
                end
                MSS_S_RVS_CHK: begin
                    state_nxt = (period_r < rvs_win) ? MSS_S_SPEED_DET : MSS_S_RD_CHECK;
                    cnt_nxt = '0;
                end
                MSS_S_RD_CHECK: begin
                    state_nxt = rd_en ? MSS_S_RVS_DRIVE : MSS_S_BRK_CHECK;
                end
                MSS_S_RVS_DRIVE: begin
                    if (rate_r == 16'h0000) begin
                        run_nxt = MSS_S2_ACCEL;
                    end
                end
                MSS_S_BRK_CHECK: begin
                    state_nxt = (brk_time != 3'h0) ? MSS_S_BRAKE : MSS_S_PRB_CHECK;
                    cnt_nxt = '0;
                end
                MSS_S_BRAKE: begin
                    if (!brk_low_s) begin
                        cnt_nxt = '0;
                    end else if (cnt_r >= brk_win) begin
                        state_nxt = MSS_S_PRB_CHECK;
                    end
                end
                MSS_S_PRB_CHECK: begin
                    state_nxt = (prb_lim != 4'h0) ? MSS_S_PROBE : MSS_S_SETTLE;
                    cnt_nxt = '0;
                end
                MSS_S_PROBE: begin
                    if (probe_gap_r) begin
                        if (cnt_r >= MSS_CNT_W'(MSS_PROBE_MAX_CYC)) begin
                            cnt_nxt = '0;
                            if (pair_r == MSS_NUM_PAIRS - 3'h1) begin
                                run_nxt = MSS_S2_ACCEL;
                            end
                        end
                    end else if (probe_hit) begin
                        cnt_nxt = '0;
                    end
                end
                MSS_S_SETTLE: begin
                    if (cnt_r >= settle_win) begin
                        run_nxt = MSS_S2_ACCEL;
                    end
                end
                default: begin
                    state_nxt = MSS_S_POWER_ON;
                end
            endcase
        end
    end

    // Probe bookkeeping and speed measurement
    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            pair_r <= 3'h0;
            best_pair_r <= 3'h0;
            best_r <= '1;
            probe_gap_r <= 1'b0;
            period_r <= '1;
            rise_cnt_r <= 2'h0;
            fwd_r <= 1'b0;
            last_edge_r <= 3'h0;
        end else begin
            if (state_r == MSS_S_PROBE && run_r == MSS_S2_NONE) begin
                if (!probe_gap_r && probe_hit) begin
                    probe_gap_r <= 1'b1;
                    if (cnt_r < best_r) begin
                        best_r <= cnt_r;
                        best_pair_r <= pair_r;
                    end
                end else if (probe_gap_r && cnt_r >= MSS_CNT_W'(MSS_PROBE_MAX_CYC)) begin
                    probe_gap_r <= 1'b0;
                    pair_r <= pair_r + 3'h1;
                end
            end
            if (state_r == MSS_S_SPEED_DET && run_r == MSS_S2_NONE && any_rise) begin
                if (rise_cnt_r != 2'h3) begin
                    rise_cnt_r <= rise_cnt_r + 2'h1;
                end
                period_r <= cnt_r;
                // UV rising with UW high: UW leads; UV rising with UW low: UW lags
                if (edges.uv_rise) begin
                    fwd_r <= ~edges.uw_lvl;
                end
                last_edge_r <= {edges.uw_lvl, edges.uw_lvl, edges.uv_lvl};
            end else if (state_r == MSS_S_RVS_CHK) begin
                rise_cnt_r <= 2'h0;
            end
        end
    end

    // Open-loop rate ramp; reverse drive starts negative in magnitude terms
    wire [15:0] acc_step = {13'h0000, acc1} + 16'h0001;
    wire [15:0] acc2_step = {13'h0000, acc2};
    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            rate_r <= 16'h0000;
            accel_r <= 16'h0000;
        end else if (state_r == MSS_S_RVS_CHK) begin
            rate_r <= 16'(MSS_CNT_W'(16'hffff) / (period_r | 24'h1));
        end else if (state_r == MSS_S_RVS_DRIVE && run_r == MSS_S2_NONE && cnt_r[9:0] == 10'h000) begin
            rate_r <= (rate_r > acc_step) ? rate_r - acc_step : 16'h0000;
        end else if (run_r == MSS_S2_ACCEL && cnt_r[9:0] == 10'h000) begin
            accel_r <= accel_r + acc2_step;
            rate_r <= rate_r + acc_step + accel_r;
        end
    end

    // Phase gates
    logic [2:0] hi_nxt, lo_nxt;
    always_comb begin
        hi_nxt = 3'h0;
        lo_nxt = 3'h0;
        if (!restart) begin
            if (run_r == MSS_S2_NONE && state_r == MSS_S_BRAKE) begin
                lo_nxt = 3'h7;
            end else if (run_r == MSS_S2_NONE && state_r == MSS_S_SETTLE) begin
                hi_nxt = mss_onehot(MSS_PH_V);
                lo_nxt = mss_onehot(MSS_PH_W);
            end else if (run_r == MSS_S2_NONE && state_r == MSS_S_PROBE) begin
                if (!probe_gap_r) begin
                    hi_nxt = mss_onehot(cur_pair[3:2]);
                    lo_nxt = mss_onehot(cur_pair[1:0]);
                end else if (!rel_md) begin
                    lo_nxt = mss_onehot(cur_pair[1:0]);
                end
            end else if (run_r == MSS_S2_NONE && state_r == MSS_S_RVS_DRIVE) begin
                hi_nxt = mss_onehot(MSS_PH_V);
                lo_nxt = mss_onehot(MSS_PH_W);
            end
        end
    end

    // Avalon slave: one wait cycle then acknowledge
    wire req = (avs_read | avs_write) & ~ack_r;
    wire hit_ctrl = avs_address == MSS_REG_CTRL;
    wire hit_start = avs_address == MSS_REG_START;
    wire hit_status = avs_address == MSS_REG_STATUS;
    wire hit_speed = avs_address == MSS_REG_SPEED;
    wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                         hit_start ? start_r :
                         hit_status ? {14'h0, run_r, 3'h0, state_r} :
                         hit_speed ? {rate_r, 16'(period_r)} : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= MSS_S_POWER_ON;
            run_r <= MSS_S2_NONE;
            cnt_r <= '0;
            dir_prev_r <= 1'b0;
            stby_prev_r <= 1'b0;
            ctrl_r <= MSS_CTRL_RST;
            start_r <= MSS_START_RST;
            ack_r <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            high_on <= 3'h0;
            low_on <= 3'h0;
            closed_loop <= 1'b0;
            accel_active <= 1'b0;
            open_loop_current_level <= 2'h0;
            drive_phase_init <= 3'h0;
            drive_rate <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            run_r <= run_nxt;
            cnt_r <= cnt_nxt;
            dir_prev_r <= dir_s;
            stby_prev_r <= stby_s;
            ack_r <= req;
            avs_waitrequest <= ~req;
            if (req && avs_read) begin
                avs_readdata <= rd_mux;
            end
            if (ack_r && avs_write && hit_ctrl) begin
                ctrl_r <= avs_writedata;
            end
            if (ack_r && avs_write && hit_start) begin
                start_r <= avs_writedata;
            end
            high_on <= hi_nxt;
            low_on <= lo_nxt;
            closed_loop <= run_nxt == MSS_S2_CLOSED;
            accel_active <= run_nxt == MSS_S2_ACCEL;
            open_loop_current_level <= ctrl_r[MSS_F_OLC_LO +: 2];
            if (state_r == MSS_S_FWD_CHK && fwd_r) begin
                drive_phase_init <= last_edge_r;
            end else if (state_r == MSS_S_PROBE && run_nxt == MSS_S2_ACCEL) begin
                drive_phase_init <= best_pair_r + {1'b0, adv};
            end
            drive_rate <= rate_r;
        end
    end
endmodule : mss_sequencer

/* verif/mss_checker.sv */
// Port-level assertions for the motor start sequencer
`timescale 1ns/10ps
module mss_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Pins
    input wire logic standby,
    input wire logic dir_pin,
    // Drive outputs
    input wire logic [2:0] high_on,
    input wire logic [2:0] low_on,
    input wire logic closed_loop,
    input wire logic accel_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_standby_held;
        standby [*6];
    endsequence
    AST_ACK_ONE: assert property (s_req_taken |=> s_ack)
        else $error("bus answer not a single low cycle after the request");
    AST_ACK_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest low without a request");
    AST_IDLE_HIGH: assert property (!(avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    AST_RELEASE: assert property ($fell(rst) |-> high_on == 3'h0 && low_on == 3'h0 && !closed_loop)
        else $error("drive active at reset release");
    AST_NO_SHORT: assert property ((high_on & low_on) == 3'h0)
        else $error("high and low switch of one phase on together");
    AST_CLOSED_EXCL: assert property (!(closed_loop && accel_active))
        else $error("accelerate and closed loop at once");
    AST_STANDBY: assert property (s_standby_held |-> high_on == 3'h0 && low_on == 3'h0 && !closed_loop)
        else $error("motor driven while held in standby");
    AST_DIR_STOP: assert property ($changed(dir_pin) |-> ##[1:8] (high_on == 3'h0 && low_on == 3'h0))
        else $error("drive not stopped after direction change");
endmodule : mss_checker

/* verif/mss_motor_model.sv */
// Behavioural three-phase motor: comparators and current sense
`timescale 1ns/10ps
module mss_motor_model (
    // Clock and spin command (0 still, 1 forward, 2 reverse)
    input wire logic ref_clk,
    input wire logic [1:0] spin,
    // Switch gates
    input wire logic [2:0] high_on,
    input wire logic [2:0] low_on,
    // Sense outputs
    output logic cmp_uv,
    output logic cmp_uw,
    output logic cur_below_brake,
    output logic cur_at_probe
);
    logic [2:0] step_r = 3'h0;
    logic [7:0] div_r = 8'h00;
    logic [11:0] pulse_r = 12'h000;
    always_ff @(posedge ref_clk) begin
        div_r <= (div_r == 8'h63) ? 8'h00 : div_r + 8'h01;
        if (spin != 2'h0 && div_r == 8'h63) begin
            step_r <= (step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
        end
        pulse_r <= (high_on != 3'h0) ? pulse_r + 12'h001 : 12'h000;
    end
    assign cmp_uv = step_r < 3'h3;
    // One step is 60 electrical degrees
    assign cmp_uw = (spin == 2'h2) ? (step_r == 3'h5 || step_r < 3'h2) : (step_r >= 3'h1 && step_r <= 3'h3);
    // A spinning rotor keeps current up under the brake
    assign cur_below_brake = !(spin != 2'h0 && low_on == 3'h7);
    // Rise time depends on the high phase only, so UV and UW tie for the minimum
    assign cur_at_probe = pulse_r >= 12'h028 + {6'h00, high_on, 3'h0};
endmodule : mss_motor_model

/* verif/test_bldc_motor_start_sequencer.sv */
// Self-checking bench for the motor start sequencer
`timescale 1ns/10ps
module test_bldc_motor_start_sequencer;
    import mss_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic standby = 1'b0;
    logic dir_pin = 1'b0;
    logic cmp_uv, cmp_uw, cur_below_brake, cur_at_probe, closed_loop, accel_active;
    logic [2:0] high_on, low_on, drive_phase_init;
    logic [1:0] open_loop_current_level;
    logic [1:0] spin = 2'h0;
    logic [15:0] drive_rate;
    int err_total = 0;
    int total_checks = 0;
    always #5 ref_clk = ~ref_clk;
    mss_sequencer dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .standby(standby), .dir_pin(dir_pin), .cmp_uv(cmp_uv),
        .cmp_uw(cmp_uw), .cur_below_brake(cur_below_brake), .cur_at_probe(cur_at_probe), .phase_seed(3'h0),
        .high_on(high_on), .low_on(low_on), .closed_loop(closed_loop), .accel_active(accel_active),
        .open_loop_current_level(open_loop_current_level), .drive_phase_init(drive_phase_init),
        .drive_rate(drive_rate));
    mss_motor_model motor_u (.ref_clk(ref_clk), .spin(spin), .high_on(high_on), .low_on(low_on),
        .cmp_uv(cmp_uv), .cmp_uw(cmp_uw), .cur_below_brake(cur_below_brake), .cur_at_probe(cur_at_probe));
    task finish_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low at an edge
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !we;
        avs_write <= we;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) err_total++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd_chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task wait_state(input mss_state_t s);
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        while (q[12:0] !== s && n < 400) begin
            bus(1'b0, MSS_REG_STATUS, 32'h0, q);
            n++;
        end
        chk(q & 32'h0000_1fff, {19'h0, s});
    endtask : wait_state
    // Config is only sampled on a fresh run, so restart through the direction pin
    task restart;
        @(posedge ref_clk);
        dir_pin <= ~dir_pin;
        repeat (4) @(posedge ref_clk);
    endtask : restart
    task t_regs;
        rd_chk(MSS_REG_CTRL, MSS_CTRL_RST);
        rd_chk(MSS_REG_START, MSS_START_RST);
        wr(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, 32'h0);
        wr(MSS_REG_START, 32'h0000_1a5b);
        rd_chk(MSS_REG_START, 32'h0000_1a5b);
    endtask : t_regs
    task t_standby;
        standby <= 1'b1;
        repeat (8) @(posedge ref_clk);
        wait_state(MSS_S_POWER_ON);
        chk({26'h0, high_on, low_on}, 32'h0);
        standby <= 1'b0;
        wait_state(MSS_S_SPEED_DET);
        chk({26'h0, high_on, low_on}, 32'h0);
    endtask : t_standby
    task t_brake;
        spin <= 2'h1;
        wr(MSS_REG_CTRL, 32'h1 << MSS_F_BRK_T_LO);
        restart();
        wait_state(MSS_S_BRAKE);
        chk({26'h0, high_on, low_on}, 32'h0000_0007);
        repeat (3000) @(posedge ref_clk);
        wait_state(MSS_S_BRAKE);
    endtask : t_brake
    task t_align;
        spin <= 2'h0;
        wr(MSS_REG_CTRL, 32'h2 << MSS_F_OLC_LO);
        restart();
        wait_state(MSS_S_SETTLE);
        chk({26'h0, high_on, low_on}, 32'h0000_0014);
        chk({30'h0, open_loop_current_level}, 32'h2);
    endtask : t_align
    task t_probe;
        int n;
        wr(MSS_REG_CTRL, 32'h1 << MSS_F_PRB_I_LO | 32'h1 << MSS_F_REL_MD);
        restart();
        wait_state(MSS_S_PROBE);
        for (n = 0; n < 3000 && high_on === 3'h0; n++) @(posedge ref_clk);
        chk({26'h0, high_on, low_on}, 32'h0000_0014);
        for (n = 0; n < 3000 && high_on !== 3'h0; n++) @(posedge ref_clk);
        chk({26'h0, high_on, low_on}, 32'h0);
        for (n = 0; n < 30000 && accel_active !== 1'b1; n++) @(posedge ref_clk);
        chk({31'h0, accel_active}, 32'h1);
        chk({29'h0, drive_phase_init}, 32'h2);
    endtask : t_probe
    task t_fwd;
        int n;
        spin <= 2'h1;
        wr(MSS_REG_CTRL, 32'h1 << MSS_F_SD_EN);
        restart();
        for (n = 0; n < 40000 && closed_loop !== 1'b1; n++) @(posedge ref_clk);
        chk({30'h0, closed_loop, accel_active}, 32'h2);
        spin <= 2'h2;
        restart();
        repeat (3000) @(posedge ref_clk);
        chk({30'h0, closed_loop, accel_active}, 32'h0);
    endtask : t_fwd
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_standby();
        t_brake();
        t_align();
        t_probe();
        t_fwd();
        finish_test();
    end
    initial begin
        #1000000;
        err_total++;
        finish_test();
    end
endmodule : test_bldc_motor_start_sequencer
bind mss_sequencer mss_checker chk_u (.ref_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .standby,
    .dir_pin, .high_on, .low_on, .closed_loop, .accel_active);
